//--- rtl/acc_pkg.sv
// constants and types shared by the calibration control block
package acc_pkg;
  localparam int          ADDR_W        = 15;
  localparam int          DATA_W        = 8;
  localparam logic [4:0]  HDR_BITS      = 5'h10;
  localparam logic [4:0]  FRAME_BITS    = 5'h18;
  localparam logic [2:0]  PIN_IDLE      = 3'h2;

  localparam logic [14:0] ADDR_CFG0     = 15'h050;
  localparam logic [14:0] ADDR_CFG1     = 15'h051;
  localparam logic [14:0] ADDR_BACK     = 15'h057;
  localparam logic [14:0] ADDR_VEC      = 15'h05A;
  localparam logic [14:0] ADDR_STAT     = 15'h05B;

  localparam logic [7:0]  RST_CFG0      = 8'h06;
  localparam logic [7:0]  RST_CFG1      = 8'hF4;
  localparam logic [7:0]  RST_BACK      = 8'h10;
  localparam logic [7:0]  RST_VEC       = 8'h00;
  localparam logic [5:0]  STAT_RSV      = 6'h02;

  localparam int          B_TS          = 5;
  localparam int          B_SCAN        = 4;
  localparam int          B_TRIG        = 3;
  localparam int          RANGE_LSB     = 4;
  localparam int          RANGE_MSB     = 6;
  localparam int          B_RUN         = 1;
  localparam int          B_MODE        = 0;

  localparam int          VEC_DEPTH     = 16;
  localparam int          VEC_IDX_W     = 4;

  localparam int          CLK_PERIOD_NS = 50;
  localparam int          FG_CAL_NS     = 10000;
  localparam int          BG_PASS_NS    = 5000;
  localparam logic [15:0] FG_CAL_CYC    = 16'((FG_CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] BG_PASS_CYC   = 16'((BG_PASS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] CNT_LAST      = 16'h0001;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [14:0]       addr;
    logic [7:0]        wdata;
  } acc_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_FG, ST_BG} acc_cal_st_t;
endpackage

//--- rtl/acc_spi_slave.sv
// serial register port: oversampled pins, 24-bit frames, read and write requests
`timescale 1ns/1ps
module acc_spi_slave (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            sclk,
  input  wire logic            cs_n,
  input  wire logic            sdi,
  input  wire logic [7:0]      rdata,
  output acc_pkg::acc_req_t    req,
  output logic                 sdo,
  output logic                 sdo_oe
);
  // pin order in vectors: sclk, cs_n, sdi
  logic [2:0]          s1_q;
  logic [2:0]          s2_q;
  logic [2:0]          s3_q;
  logic [2:0]          filt_q;
  logic [2:0]          filt_d;
  logic                sclk_prev_q;
  logic [4:0]          cnt_q;
  logic [4:0]          cnt_d;
  logic [23:0]         sh_q;
  logic [23:0]         sh_d;
  logic [7:0]          out_q;
  logic [7:0]          out_d;
  logic                sdo_q;
  logic                sdo_d;
  logic                oe_q;
  logic                oe_d;
  acc_pkg::acc_req_t   req_q;
  acc_pkg::acc_req_t   req_d;
  logic                rise;
  logic                fall;
  logic                rd_fr_q;
  logic                rd_fr_d;

  assign req    = req_q;
  assign sdo    = sdo_q;
  assign sdo_oe = oe_q;

  always_comb
  begin
    // a level change counts once the second and third stages agree
    filt_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    rise   = filt_q[2] & ~sclk_prev_q;
    fall   = ~filt_q[2] & sclk_prev_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    out_d  = out_q;
    sdo_d  = sdo_q;
    oe_d   = oe_q;
    req_d  = '0;
    // read frame flag: the read bit leaves a fixed shift position as data arrives
    rd_fr_d = rd_fr_q;
    if (req_q.rd)
    begin
      out_d = rdata;
    end
    if (filt_q[1])
    begin
      cnt_d = '0;
      oe_d  = 1'b0;
      rd_fr_d = 1'b0;
    end
    else
    begin
      if (rise && cnt_q < acc_pkg::FRAME_BITS)
      begin
        sh_d  = {sh_q[22:0], filt_q[0]};
        cnt_d = cnt_q + 5'h01;
        if (cnt_q == acc_pkg::HDR_BITS - 5'h01 && sh_q[14])
        begin
          req_d.rd   = 1'b1;
          rd_fr_d    = 1'b1;
          req_d.addr = {sh_q[13:0], filt_q[0]};
        end
        if (cnt_q == acc_pkg::FRAME_BITS - 5'h01 && !sh_q[22])
        begin
          req_d.wr    = 1'b1;
          req_d.addr  = sh_q[21:7];
          req_d.wdata = {sh_q[6:0], filt_q[0]};
        end
      end
      if (fall && rd_fr_q && cnt_q < acc_pkg::FRAME_BITS)
      begin
        sdo_d = out_q[7];
        out_d = {out_q[6:0], 1'b0};
        oe_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q        <= acc_pkg::PIN_IDLE;
      s2_q        <= acc_pkg::PIN_IDLE;
      s3_q        <= acc_pkg::PIN_IDLE;
      filt_q      <= acc_pkg::PIN_IDLE;
      sclk_prev_q <= 1'b0;
      cnt_q       <= '0;
      sh_q        <= '0;
      out_q       <= '0;
      sdo_q       <= 1'b0;
      oe_q        <= 1'b0;
      req_q       <= '0;
      rd_fr_q     <= 1'b0;
    end
    else
    begin
      s1_q        <= {sclk, cs_n, sdi};
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      filt_q      <= filt_d;
      sclk_prev_q <= filt_q[2];
      cnt_q       <= cnt_d;
      sh_q        <= sh_d;
      out_q       <= out_d;
      sdo_q       <= sdo_d;
      oe_q        <= oe_d;
      req_q       <= req_d;
      rd_fr_q     <= rd_fr_d;
    end
  end
endmodule

//--- rtl/acc_cal_ctrl.sv
// calibration control register group with calibration sequencer and scan store
`timescale 1ns/1ps
// Notes on behaviour
// R1: time-stamp enable, bit 5 of config zero, captures the time-stamp input; resets 0.
// R2: scan enable, bit 4, opens vector register 0x05A to scan access; resets 0.
// R3: writing one to trigger bit 3 starts foreground calibration; bit self-clears.
// R4: trigger first resets the calibration state machine, then the sequence proceeds.
// R5: host finishes all calibration setting changes before setting the trigger.
// R6: host writes setting changes first, trigger only after all are written.
// R7: after triggering, host toggles the serial-link enable off and on.
// R8: range field bits 6-4: 111 low amplitude (reset), 000 near full scale.
// R9: only the run bit accepts changes while background calibration runs.
// R10: run bit 1 starts background calibration at 1, pauses it at 0.
// R11: host pauses background by clearing only run, leaving mode bit 0 set.
// R12: clearing mode after background ran may abort; a foreground trigger recovers.
// R13: with scan enabled, successive vector reads and writes step through stored values.
// R14: stopped flag reads 0 while calibrating, 1 once finished or stopped.
// R15: reserved bits store and read back as written, with their reset patterns.
module acc_cal_ctrl (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic        SCLK,
  input  wire logic        SCSB,
  input  wire logic        SDI,
  input  wire logic        TIMESTAMP,
  output logic             SDO,
  output logic             SDO_OE,
  output logic             TS_CAPTURE,
  output logic [2:0]       SIGNAL_RANGE,
  output logic             BG_MODE,
  output logic             CAL_ENGINE_RESET,
  output logic             CAL_RUNNING
);
  localparam int          VEC_IDX_W_L = acc_pkg::VEC_IDX_W;
  localparam logic [15:0] CNT_ONE     = 16'h0001;

  acc_pkg::acc_req_t      req;
  logic [7:0]             rdata;
  logic [7:0]             cfg0_q;
  logic [7:0]             cfg0_d;
  logic [7:0]             cfg1_q;
  logic [7:0]             cfg1_d;
  logic [7:0]             back_q;
  logic [7:0]             back_d;
  logic [VEC_IDX_W_L-1:0] vidx_q;
  logic [VEC_IDX_W_L-1:0] vidx_d;
  logic [7:0]             vec_q [acc_pkg::VEC_DEPTH];
  logic                   vec_we;
  acc_pkg::acc_cal_st_t   st_q;
  acc_pkg::acc_cal_st_t   st_d;
  logic [15:0]            cnt_q;
  logic [15:0]            cnt_d;
  logic                   done_q;
  logic                   done_d;
  logic                   stopped_q;
  logic                   stopped_d;
  logic                   eng_rst_q;
  logic                   eng_rst_d;
  logic                   run_q;
  logic                   run_d;
  logic [2:0]             ts_sync_q;
  logic                   ts_filt_q;
  logic                   ts_filt_d;
  logic                   ts_cap_q;
  logic                   ts_cap_d;
  logic                   bg_lock;

  acc_spi_slave u_spi (
    .clk    (CLOCK),
    .rst_n  (RSTN),
    .sclk   (SCLK),
    .cs_n   (SCSB),
    .sdi    (SDI),
    .rdata  (rdata),
    .req    (req),
    .sdo    (SDO),
    .sdo_oe (SDO_OE)
  );

  assign SIGNAL_RANGE     = cfg1_q[acc_pkg::RANGE_MSB:acc_pkg::RANGE_LSB]; // R8
  assign BG_MODE          = back_q[acc_pkg::B_MODE];
  assign CAL_ENGINE_RESET = eng_rst_q;
  assign CAL_RUNNING      = run_q;
  assign TS_CAPTURE       = ts_cap_q;
  assign bg_lock          = (st_q == acc_pkg::ST_BG);

  // register file: read mux, writes, self-clearing trigger, scan index
  always_comb
  begin
    cfg0_d = cfg0_q;
    cfg1_d = cfg1_q;
    back_d = back_q;
    vidx_d = vidx_q;
    vec_we = 1'b0;
    rdata  = '0;
    if (cfg0_q[acc_pkg::B_TRIG])
    begin
      cfg0_d[acc_pkg::B_TRIG] = 1'b0; // R3
    end
    if (!cfg0_q[acc_pkg::B_SCAN])
    begin
      vidx_d = '0;
    end
    if (req.rd)
    begin
      unique case (req.addr)
        acc_pkg::ADDR_CFG0: rdata = cfg0_q; // R15
        acc_pkg::ADDR_CFG1: rdata = cfg1_q;
        acc_pkg::ADDR_BACK: rdata = back_q;
        acc_pkg::ADDR_STAT: rdata = {acc_pkg::STAT_RSV, stopped_q, done_q}; // R14
        acc_pkg::ADDR_VEC:
        begin
          if (cfg0_q[acc_pkg::B_SCAN])
          begin
            rdata  = vec_q[vidx_q]; // R13
            vidx_d = vidx_q + 1'b1;
          end
        end
        default: rdata = '0;
      endcase
    end
    if (req.wr)
    begin
      unique case (req.addr)
        acc_pkg::ADDR_CFG0:
        begin
          if (!bg_lock)
          begin
            cfg0_d = req.wdata; // R15
          end
        end
        acc_pkg::ADDR_CFG1:
        begin
          if (!bg_lock)
          begin
            cfg1_d = req.wdata; // R9
          end
        end
        acc_pkg::ADDR_BACK:
        begin
          if (bg_lock)
          begin
            back_d[acc_pkg::B_RUN] = req.wdata[acc_pkg::B_RUN]; // R9
          end
          else
          begin
            back_d = req.wdata;
          end
        end
        acc_pkg::ADDR_VEC:
        begin
          if (cfg0_q[acc_pkg::B_SCAN] && !bg_lock)
          begin
            vec_we = 1'b1; // R2
            vidx_d = vidx_q + 1'b1; // R13
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cfg0_q <= acc_pkg::RST_CFG0;
      cfg1_q <= acc_pkg::RST_CFG1;
      back_q <= acc_pkg::RST_BACK;
      vidx_q <= '0;
    end
    else
    begin
      cfg0_q <= cfg0_d;
      cfg1_q <= cfg1_d;
      back_q <= back_d;
      vidx_q <= vidx_d;
    end
  end

  // calibration vector store, one register per entry
  genvar gi;
  generate
    for (gi = 0; gi < acc_pkg::VEC_DEPTH; gi++)
    begin : g_vec
      always_ff @(posedge CLOCK or negedge RSTN)
      begin
        if (!RSTN)
        begin
          vec_q[gi] <= acc_pkg::RST_VEC;
        end
        else if (vec_we && vidx_q == VEC_IDX_W_L'(gi))
        begin
          vec_q[gi] <= req.wdata; // R13
        end
      end
    end
  endgenerate

  // calibration sequencer
  always_comb
  begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    done_d    = done_q;
    eng_rst_d = 1'b0;
    unique case (st_q)
      acc_pkg::ST_IDLE:
      begin
        if (back_q[acc_pkg::B_RUN] && back_q[acc_pkg::B_MODE])
        begin
          st_d  = acc_pkg::ST_BG; // R10
          cnt_d = acc_pkg::BG_PASS_CYC;
        end
      end
      acc_pkg::ST_INIT:
      begin
        st_d  = acc_pkg::ST_FG; // R4
        cnt_d = acc_pkg::FG_CAL_CYC;
      end
      acc_pkg::ST_FG:
      begin
        cnt_d = cnt_q - CNT_ONE;
        if (cnt_q == acc_pkg::CNT_LAST)
        begin
          st_d   = acc_pkg::ST_IDLE;
          done_d = 1'b1;
        end
      end
      acc_pkg::ST_BG:
      begin
        cnt_d = cnt_q - CNT_ONE;
        if (!back_q[acc_pkg::B_MODE])
        begin
          st_d = acc_pkg::ST_IDLE; // R12
        end
        else if (cnt_q == acc_pkg::CNT_LAST)
        begin
          done_d = 1'b1;
          cnt_d  = acc_pkg::BG_PASS_CYC;
          if (!back_q[acc_pkg::B_RUN])
          begin
            st_d = acc_pkg::ST_IDLE; // R10
          end
        end
      end
    endcase
    if (cfg0_q[acc_pkg::B_TRIG])
    begin
      st_d      = acc_pkg::ST_INIT; // R3 R4
      cnt_d     = '0;
      eng_rst_d = 1'b1;
    end
    stopped_d = (st_d == acc_pkg::ST_IDLE); // R14
    run_d     = !stopped_d;
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_q      <= acc_pkg::ST_IDLE;
      cnt_q     <= '0;
      done_q    <= 1'b0;
      stopped_q <= 1'b1;
      eng_rst_q <= 1'b0;
      run_q     <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      done_q    <= done_d;
      stopped_q <= stopped_d;
      eng_rst_q <= eng_rst_d;
      run_q     <= run_d;
    end
  end

  // time-stamp input: three-stage capture, gated by the enable bit
  always_comb
  begin
    ts_filt_d = (ts_sync_q[1] == ts_sync_q[2]) ? ts_sync_q[2] : ts_filt_q;
    ts_cap_d  = cfg0_q[acc_pkg::B_TS] & ts_filt_q; // R1
  end

  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ts_sync_q <= '0;
      ts_filt_q <= 1'b0;
      ts_cap_q  <= 1'b0;
    end
    else
    begin
      ts_sync_q <= {ts_sync_q[1:0], TIMESTAMP};
      ts_filt_q <= ts_filt_d;
      ts_cap_q  <= ts_cap_d;
    end
  end
endmodule

//--- bench/acc_cal_checker.sv
// port assertions for the calibration control block
`timescale 1ns/1ps
module acc_cal_checker (
  input wire logic       CLOCK,
  input wire logic       RSTN,
  input wire logic       SCLK,
  input wire logic       SCSB,
  input wire logic       SDI,
  input wire logic       TIMESTAMP,
  input wire logic       SDO,
  input wire logic       SDO_OE,
  input wire logic       TS_CAPTURE,
  input wire logic [2:0] SIGNAL_RANGE,
  input wire logic       BG_MODE,
  input wire logic       CAL_ENGINE_RESET,
  input wire logic       CAL_RUNNING
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  AST_RST_VAL: assert property (!$past(RSTN) |-> SIGNAL_RANGE == 3'h7 && !CAL_RUNNING)
    else $error("bad reset outputs");
  AST_ENG_PULSE: assert property (CAL_ENGINE_RESET |=> !CAL_ENGINE_RESET)
    else $error("engine reset too long");
  AST_ENG_RUN: assert property (CAL_ENGINE_RESET |-> CAL_RUNNING)
    else $error("engine reset while idle");
  AST_ENG_CAUSE: assert property ($rose(CAL_RUNNING) && !BG_MODE |-> ##[0:2] CAL_ENGINE_RESET)
    else $error("no engine reset");
  AST_FG_HOLD: assert property (CAL_ENGINE_RESET && !BG_MODE |-> ##100 CAL_RUNNING)
    else $error("foreground too short");
  AST_FG_END: assert property (CAL_ENGINE_RESET && !BG_MODE |-> ##[101:260] !CAL_RUNNING)
    else $error("foreground never ends");
  AST_TS_LOW: assert property (!TIMESTAMP [*6] |-> !TS_CAPTURE)
    else $error("stamp not tracking");
  AST_RANGE_LOCK: assert property ($past(BG_MODE && CAL_RUNNING) && BG_MODE && CAL_RUNNING
    |-> $stable(SIGNAL_RANGE))
    else $error("range changed in background");
  AST_MODE_LOCK: assert property ($past(BG_MODE && CAL_RUNNING) |-> BG_MODE)
    else $error("mode changed in background");
  AST_OE_OFF: assert property (SCSB [*6] |-> !SDO_OE)
    else $error("read data driven while deselected");

  C_FG: cover property (CAL_ENGINE_RESET);
  C_BG: cover property (BG_MODE && CAL_RUNNING);
  C_TS: cover property (TS_CAPTURE);
endmodule

bind acc_cal_ctrl acc_cal_checker i_chk (
  .CLOCK, .RSTN, .SCLK, .SCSB, .SDI, .TIMESTAMP, .SDO, .SDO_OE,
  .TS_CAPTURE, .SIGNAL_RANGE, .BG_MODE, .CAL_ENGINE_RESET, .CAL_RUNNING
);

//--- bench/testbench.sv
// self-checking bench for the calibration control block
`timescale 1ns/1ps
module testbench;
  logic       clock;
  logic       rst_n;
  logic       sclk;
  logic       cs_n;
  logic       sdi;
  logic       tstamp;
  logic       sdo;
  logic       sdo_oe;
  logic       ts_cap;
  logic [2:0] range;
  logic       bg_mode;
  logic       eng_rst;
  logic       running;
  logic [7:0] rd;
  logic       oe;
  int         errors;
  int         comparisons;

  acc_cal_ctrl i_dut (
    .CLOCK(clock), .RSTN(rst_n), .SCLK(sclk), .SCSB(cs_n), .SDI(sdi),
    .TIMESTAMP(tstamp), .SDO(sdo), .SDO_OE(sdo_oe), .TS_CAPTURE(ts_cap),
    .SIGNAL_RANGE(range), .BG_MODE(bg_mode), .CAL_ENGINE_RESET(eng_rst),
    .CAL_RUNNING(running)
  );

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", w, e, s);
    end
  endtask

  // 24-bit frame, msb first, serial clock half period of 10 cycles
  task automatic xfer(input logic r, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] f;
    f = {r, a, d};
    oe = 1'b0;
    @(posedge clock);
    cs_n <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdi <= f[i];
      cyc(10);
      sclk <= 1'b1;
      rd = {rd[6:0], sdo};
      oe = oe | sdo_oe;
      cyc(10);
      sclk <= 1'b0;
    end
    cyc(10);
    cs_n <= 1'b1;
    cyc(10);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
    chk("sdo_oe wr", {7'h00, oe}, 8'h00);
  endtask

  task automatic rchk(input string w, input logic [14:0] a, input logic [7:0] e);
    xfer(1'b1, a, 8'h00);
    chk(w, rd, e);
    chk("sdo_oe rd", {7'h00, oe}, 8'h01);
  endtask

  task automatic reg_reset();
    chk("range", {5'h00, range}, 8'h07);
    rchk("cfg0", 15'h050, 8'h06);
    rchk("cfg1", 15'h051, 8'hF4);
    rchk("back", 15'h057, 8'h10);
    rchk("stat", 15'h05B, 8'h0A);
    rchk("unmapped", 15'h052, 8'h00);
  endtask

  task automatic range_sel();
    wr(15'h051, 8'h0F);
    chk("range", {5'h00, range}, 8'h00);
    rchk("cfg1", 15'h051, 8'h0F);
  endtask

  task automatic time_stamp();
    tstamp <= 1'b1;
    cyc(8);
    chk("ts off", {7'h00, ts_cap}, 8'h00);
    wr(15'h050, 8'h26);
    chk("ts on", {7'h00, ts_cap}, 8'h01);
    tstamp <= 1'b0;
    cyc(8);
    chk("ts low", {7'h00, ts_cap}, 8'h00);
  endtask

  task automatic fg_cal();
    wr(15'h050, 8'hC6);
    wr(15'h050, 8'hCE);
    chk("fg run", {7'h00, running}, 8'h01);
    // link restart after the trigger: clear the link control, then restore it
    wr(15'h201, 8'h00);
    wr(15'h201, 8'h0F);
    rchk("cfg0", 15'h050, 8'hC6);
    chk("fg done", {7'h00, running}, 8'h00);
    rchk("stat", 15'h05B, 8'h0B);
  endtask

  task automatic scan_path();
    wr(15'h050, 8'h16);
    for (int k = 1; k <= 3; k++)
      wr(15'h05A, 8'(k * 8'h11));
    wr(15'h050, 8'h06);
    wr(15'h05A, 8'hFF);
    rchk("vec off", 15'h05A, 8'h00);
    wr(15'h050, 8'h16);
    for (int k = 1; k <= 3; k++)
      rchk("vec", 15'h05A, 8'(k * 8'h11));
  endtask

  task automatic bg_cal();
    int n;
    wr(15'h057, 8'h13);
    chk("bg on", {6'h00, bg_mode, running}, 8'h03);
    rchk("stat", 15'h05B, 8'h09);
    wr(15'h051, 8'hFA);
    chk("range", {5'h00, range}, 8'h00);
    wr(15'h057, 8'h12);
    chk("mode", {7'h00, bg_mode}, 8'h01);
    wr(15'h057, 8'h11);
    n = 0;
    while (running !== 1'b0 && n < 150)
    begin
      cyc(1);
      n++;
    end
    chk("bg stop", {6'h00, bg_mode, running}, 8'h02);
    rchk("stat", 15'h05B, 8'h0B);
    rchk("back", 15'h057, 8'h11);
    wr(15'h057, 8'h10);
    wr(15'h050, 8'h0E);
    chk("recover", {6'h00, bg_mode, running}, 8'h01);
  endtask

  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    rst_n = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    tstamp = 1'b0;
    rd = 8'h00;
    errors = 0;
    comparisons = 0;
    cyc(12);
    rst_n <= 1'b1;
    cyc(2);
    reg_reset();
    range_sel();
    time_stamp();
    fg_cal();
    scan_path();
    bg_cal();
    finish_test();
  end

  initial
  begin
    cyc(30000);
    errors++;
    finish_test();
  end
endmodule
